//--- i2c_flag_defs.vh
// Register map, field positions and reset values of the status-flag block.
// Contract
// (R1) No hold, no new byte at transmit slot: resend old byte, raise overrun.
// (R2) No hold, byte arrives while old unread: drop new byte, raise overrun.
// (R3) Missing acknowledge sets bit 10; cleared by writing zero or disable.
// (R4) Lost arbitration sets bit 9 and releases bus; write-zero or disable clears.
// (R5) Misplaced start or stop sets bit 8; write-zero or disable clears.
// (R6) Bit 7 empty in transmit; cleared by data write, start/stop, disable.
// (R7) Bit 6 byte waiting; cleared by data read or write, or disable.
// (R8) Slave stop after acknowledge sets bit 4; status1 read then control write clears.
// (R9) Ten-bit first header sent sets bit 3; status1 read then control write clears.
// (R10) With hold: bit 2 on transmit with nothing loaded, or receive unread.
// (R11) Master address flag after final address byte acknowledge, 7 or 10 bit.
// (R12) Slave address match sets bit 1; status1 then status2 read clears.
// (R13) Start sent sets bit 0; status1 read then data write clears.
// (R14) Packet check value in status2 bits 15..8 when checking enabled.
// (R15) Status2 bit 7 shows second-address match; cleared on start, stop, disable.
// (R16) Bit 6 on host address with host role and resolution on.
// (R17) Bit 5 on device default address with resolution on.
// (R18) Bit 4 on general call address with broadcast acceptance on.
// (R19) Bit 2 direction from address R/W; cleared stop, restart, arbitration loss, disable.
// (R20) Bit 1 busy while a line is low; stop clears; runs when disabled.
// (R21) Bit 0 master role on sent start; cleared stop, arbitration loss, disable.
// (R22) Writing one to a write-zero flag leaves it unchanged.
`ifndef I2C_FLAG_DEFS_VH
`define I2C_FLAG_DEFS_VH
`define OFS_CTRL        4'h0
`define OFS_DATA        4'h4
`define OFS_EVENT       4'h8
`define OFS_BUS         4'hc
`define CTRL_ON         0
`define CTRL_NOHOLD     1
`define CTRL_PEC        2
`define CTRL_SMBROLE    3
`define CTRL_ARP        4
`define CTRL_BCAST      5
`define CTRL_RESET      6'h00
`define EV_OVR          11
`define EV_AF           10
`define EV_ARB_LOST_FLAG         9
`define EV_BUS_ERROR_FLAG         8
`define EV_TXE          7
`define EV_RX_NOT_EMPTY_FLAG         6
`define EV_STOP_SEEN_FLAG        4
`define EV_TEN_BIT_HEADER_SENT        3
`define EV_BTF          2
`define EV_ADDR         1
`define EV_SB           0
`define BS_PEC_LSB      8
`define BS_DUAL         7
`define BS_HOST         6
`define BS_DEFAULT      5
`define BS_GCALL        4
`define BS_TRA          2
`define BS_BUSY         1
`define BS_MSL          0
`define PEC_POLY        8'h07
`define PEC_RESET       8'h00
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

//--- i2c_line_watch.v
// Two-flop synchronisers on SDA and SCL with start and stop detection.
`timescale 1ns/1ps
`default_nettype none
module i2c_line_watch (
  input  wire aclk,
  input  wire aresetn,
  input  wire sda_in,
  input  wire scl_in,
  output reg  sda_q,
  output reg  scl_q,
  output reg  start_q,
  output reg  stop_q
);
  reg sda_m_q;
  reg scl_m_q;
  reg sda_s_q;
  reg scl_s_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sda_m_q <= 1'b1;
      scl_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_q   <= 1'b1;
      scl_q   <= 1'b1;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      sda_m_q <= sda_in;
      scl_m_q <= scl_in;
      sda_s_q <= sda_m_q;
      scl_s_q <= scl_m_q;
      sda_q   <= sda_s_q;
      scl_q   <= scl_s_q;
      // Edges compare the settled stage with its delayed copy, so the first stage feeds only the second.
      start_q <= sda_q & ~sda_s_q & scl_q & scl_s_q;
      stop_q  <= ~sda_q & sda_s_q & scl_q & scl_s_q;
    end
  end
endmodule
`default_nettype wire

//--- i2c_pec_crc.v
// Running CRC-8 packet check value over bytes on the bus.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_defs.vh"
module i2c_pec_crc (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       clear,
  input  wire       byte_valid,
  input  wire [7:0] byte_in,
  output reg  [7:0] crc_q
);
  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        r = r[7] ? ((r << 1) ^ `PEC_POLY) : (r << 1);
      end
      crc_step = r;
    end
  endfunction
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      crc_q <= `PEC_RESET;
    end else if (byte_valid) begin
      crc_q <= crc_step(crc_q, byte_in);
    end
  end
endmodule
`default_nettype wire

//--- i2c_status_flag_logic.v
// Status flags of the I2C interface with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_defs.vh"
module i2c_status_flag_logic #(
  parameter ADDR_W = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              sda_in,
  input  wire              scl_in,
  input  wire              ev_start_sent,
  input  wire              ev_stop_sent,
  input  wire              ev_addr_ack,
  input  wire              ten_bit_mode,
  input  wire              addr_second_byte,
  input  wire              ev_addr_match,
  input  wire              match_second,
  input  wire              match_host,
  input  wire              match_default,
  input  wire              match_gcall,
  input  wire              addr_rw,
  input  wire              ev_ack_missing,
  input  wire              ev_arb_lost,
  input  wire              byte_active,
  input  wire              ev_byte_rx,
  input  wire [7:0]        rx_byte,
  input  wire              ev_tx_slot,
  output reg  [7:0]        tx_byte_q,
  output reg               tx_go_q,
  output reg               tx_resend_q,
  output reg               rx_discard_q,
  output reg               hold_clock_q,
  output reg               release_bus_q
);
  reg [5:0]        ctrl_q;
  reg [7:0]        dr_q;
  reg [7:0]        pend_q;
  reg              pend_valid_q;
  reg              tx_loaded_q;
  reg              rd1_q;
  reg              ovr_q, af_q, arb_lost_flag_q, bus_error_flag_q, txe_q, rx_not_empty_flag_q;
  reg              stop_seen_flag_q, ten_bit_header_sent_q, btf_q, addr_q, sb_q;
  reg              dual_q, host_q, dflt_q, gcall_q, tra_q, busy_q, msl_q;
  reg              aw_held_q;
  reg              w_held_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0]       w_data_q;
  reg [3:0]        w_strb_q;
  wire             sda_s, scl_s, start_det, stop_det;
  wire [7:0]       pec_val;
  wire             on = ctrl_q[`CTRL_ON];
  wire             nohold = ctrl_q[`CTRL_NOHOLD];

  // Returns the register slot, or 3'b100 for an address outside the map.
  function [2:0] reg_slot;
    input [ADDR_W-1:0] a;
    begin
      if (a[ADDR_W-1:4] != {(ADDR_W-4){1'b0}} || a[1:0] != 2'b00) begin
        reg_slot = 3'b100;
      end else begin
        reg_slot = {1'b0, a[3:2]};
      end
    end
  endfunction

  i2c_line_watch u_watch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sda_in  (sda_in),
    .scl_in  (scl_in),
    .sda_q   (sda_s),
    .scl_q   (scl_s),
    .start_q (start_det),
    .stop_q  (stop_det)
  );

  i2c_pec_crc u_pec (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clear      (~on | ~ctrl_q[`CTRL_PEC] | start_det | stop_det),
    .byte_valid (ev_byte_rx | tx_go_q),
    .byte_in    (ev_byte_rx ? rx_byte : tx_byte_q),
    .crc_q      (pec_val)
  );

  localparam [3:0] OFS_C = `OFS_CTRL;
  localparam [3:0] OFS_D = `OFS_DATA;
  localparam [3:0] OFS_E = `OFS_EVENT;
  localparam [3:0] OFS_B = `OFS_BUS;
  wire do_wr = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire do_rd = s_axi_arvalid & s_axi_arready;
  wire [2:0] wslot = reg_slot(aw_addr_q);
  wire [2:0] rslot = reg_slot(s_axi_araddr);
  wire wr_ctrl = do_wr & (wslot == {1'b0, OFS_C[3:2]});
  wire wr_data = do_wr & (wslot == {1'b0, OFS_D[3:2]}) & w_strb_q[0];
  wire wr_evt  = do_wr & (wslot == {1'b0, OFS_E[3:2]});
  wire rd_data = do_rd & (rslot == {1'b0, OFS_D[3:2]});
  wire rd_evt  = do_rd & (rslot == {1'b0, OFS_E[3:2]});
  wire rd_bus  = do_rd & (rslot == {1'b0, OFS_B[3:2]});
  wire [15:0] clr0 = {16{wr_evt}} & {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}} & ~w_data_q[15:0]; // R22

  wire [15:0] evt_word = {4'h0, ovr_q, af_q, arb_lost_flag_q, bus_error_flag_q, txe_q, rx_not_empty_flag_q, 1'b0,
                          stop_seen_flag_q, ten_bit_header_sent_q, btf_q, addr_q, sb_q};
  wire [7:0] pec_shown = ctrl_q[`CTRL_PEC] ? pec_val : 8'h00; // R14
  wire [15:0] bus_word = {pec_shown, dual_q, host_q, dflt_q, gcall_q, 1'b0,
                          tra_q, busy_q, msl_q};

  wire tx_take = ev_tx_slot & tx_loaded_q;
  wire tx_miss = ev_tx_slot & ~tx_loaded_q;
  wire rx_busy = ev_byte_rx & rx_not_empty_flag_q;
  wire hold_wr = hold_clock_q & tra_q & wr_data;
  wire restart = start_det & busy_q;

  // AXI4-Lite write channel: address and data are taken in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= {ADDR_W{1'b0}};
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wslot[2] ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; reads have side effects, so each is taken exactly once.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (do_rd) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= rslot[2] ? `RESP_SLVERR : `RESP_OKAY;
        case (rslot)
          3'd0:    s_axi_rdata <= {26'h0, ctrl_q};
          3'd1:    s_axi_rdata <= {24'h0, dr_q};
          3'd2:    s_axi_rdata <= {16'h0, evt_word};
          3'd3:    s_axi_rdata <= {16'h0, bus_word};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Control bits and the data path between the register and the shift engine.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q        <= `CTRL_RESET;
      dr_q          <= 8'h00;
      pend_q        <= 8'h00;
      pend_valid_q  <= 1'b0;
      tx_loaded_q   <= 1'b0;
      tx_byte_q     <= 8'h00;
      tx_go_q       <= 1'b0;
      tx_resend_q   <= 1'b0;
      rx_discard_q  <= 1'b0;
      hold_clock_q  <= 1'b0;
      release_bus_q <= 1'b0;
      rd1_q         <= 1'b0;
    end else begin
      tx_go_q       <= 1'b0;
      tx_resend_q   <= 1'b0;
      rx_discard_q  <= 1'b0;
      release_bus_q <= ev_arb_lost & on; // R4
      if (wr_ctrl & w_strb_q[0]) begin
        ctrl_q <= w_data_q[5:0];
      end
      // The two-step clear sequences arm on a status1 read and fire on the next access.
      if (rd_evt) begin
        rd1_q <= 1'b1;
      end else if (wr_ctrl | wr_data | rd_data | rd_bus) begin
        rd1_q <= 1'b0;
      end
      if (!on) begin
        pend_valid_q <= 1'b0;
        tx_loaded_q  <= 1'b0;
        hold_clock_q <= 1'b0;
      end else begin
        if (wr_data) begin
          dr_q        <= w_data_q[7:0];
          tx_loaded_q <= ~hold_wr;
        end else if (tx_take) begin
          tx_loaded_q <= 1'b0;
        end
        if (tx_take) begin
          tx_byte_q <= dr_q;
          tx_go_q   <= 1'b1;
        end else if (tx_miss & nohold) begin
          tx_resend_q <= 1'b1; // R1
        end else if (tx_miss) begin
          hold_clock_q <= 1'b1; // R10
        end
        if (hold_wr) begin
          tx_byte_q    <= w_data_q[7:0];
          tx_go_q      <= 1'b1;
          hold_clock_q <= 1'b0;
        end
        if (ev_byte_rx & ~rx_not_empty_flag_q) begin
          dr_q <= rx_byte;
        end else if (rx_busy & nohold) begin
          rx_discard_q <= 1'b1; // R2
        end else if (rx_busy) begin
          pend_q       <= rx_byte;
          pend_valid_q <= 1'b1;
          hold_clock_q <= 1'b1; // R10
        end
        if (rd_data & pend_valid_q) begin
          dr_q         <= pend_q;
          pend_valid_q <= 1'b0;
          hold_clock_q <= 1'b0;
        end
      end
    end
  end

  // Event flags; in every flag an event in the clearing cycle wins.
  always @(posedge aclk) begin
    if (!aresetn || !on) begin
      ovr_q   <= 1'b0;
      af_q    <= 1'b0;
      arb_lost_flag_q  <= 1'b0;
      bus_error_flag_q  <= 1'b0;
      txe_q   <= 1'b0;
      rx_not_empty_flag_q  <= 1'b0;
      stop_seen_flag_q <= 1'b0;
      ten_bit_header_sent_q <= 1'b0;
      btf_q   <= 1'b0;
      addr_q  <= 1'b0;
      sb_q    <= 1'b0;
    end else begin
      ovr_q  <= (tx_miss & nohold) | (rx_busy & nohold) | (ovr_q & ~clr0[`EV_OVR]); // R1
      af_q   <= ev_ack_missing | (af_q & ~clr0[`EV_AF]); // R3
      arb_lost_flag_q <= ev_arb_lost | (arb_lost_flag_q & ~clr0[`EV_ARB_LOST_FLAG]); // R4
      bus_error_flag_q <= ((start_det | stop_det) & byte_active) | (bus_error_flag_q & ~clr0[`EV_BUS_ERROR_FLAG]); // R5
      txe_q  <= (tx_take | hold_wr) & tra_q |
                (txe_q & ~wr_data & ~ev_start_sent & ~ev_stop_sent); // R6
      rx_not_empty_flag_q <= (ev_byte_rx & ~rx_not_empty_flag_q) | (rd_data & pend_valid_q) |
                (rx_not_empty_flag_q & ~rd_data & ~wr_data & ~ev_byte_rx) | rx_busy; // R7
      stop_seen_flag_q <= (stop_det & ~msl_q & addr_q) | (stop_seen_flag_q & ~(rd1_q & wr_ctrl)); // R8
      ten_bit_header_sent_q <= (ev_addr_ack & ten_bit_mode & ~addr_second_byte) |
                 (ten_bit_header_sent_q & ~(rd1_q & wr_ctrl)); // R9
      btf_q  <= (tx_miss & ~nohold) | (rx_busy & ~nohold) |
                (btf_q & ~(rd1_q & (rd_data | wr_data)) & ~ev_start_sent & ~ev_stop_sent); // R10
      addr_q <= (ev_addr_ack & (~ten_bit_mode | addr_second_byte)) | // R11
                ev_addr_match | (addr_q & ~(rd1_q & rd_bus) & ~clr0[`EV_ADDR]); // R12
      sb_q   <= ev_start_sent | (sb_q & ~(rd1_q & wr_data)); // R13
    end
  end

  // Bus-state flags cleared by stop or disable; match flags also by start, tra_q and msl_q by lost arbitration.
  always @(posedge aclk) begin
    if (!aresetn || !on) begin
      dual_q  <= 1'b0;
      host_q  <= 1'b0;
      dflt_q  <= 1'b0;
      gcall_q <= 1'b0;
      tra_q   <= 1'b0;
      msl_q   <= 1'b0;
    end else begin
      if (ev_addr_match) begin
        dual_q  <= match_second; // R15
        host_q  <= match_host & ctrl_q[`CTRL_SMBROLE] & ctrl_q[`CTRL_ARP]; // R16
        dflt_q  <= match_default & ctrl_q[`CTRL_ARP]; // R17
        gcall_q <= match_gcall & ctrl_q[`CTRL_BCAST]; // R18
      end else if (start_det | stop_det) begin
        dual_q  <= 1'b0; // R15
        host_q  <= 1'b0; // R16
        dflt_q  <= 1'b0; // R17
        gcall_q <= 1'b0; // R18
      end
      // A slave sends when the master reads; a master sends when it writes.
      if (ev_addr_match) begin
        tra_q <= addr_rw; // R19
      end else if (ev_addr_ack & (~ten_bit_mode | addr_second_byte)) begin
        tra_q <= ~addr_rw; // R19
      end else if (stop_det | restart | ev_arb_lost) begin
        tra_q <= 1'b0; // R19
      end
      // A start sent in the cycle of a late stop still makes us master.
      if (ev_start_sent) begin
        msl_q <= 1'b1; // R21
      end else if (ev_arb_lost | stop_det) begin
        msl_q <= 1'b0; // R21
      end
    end
  end

  // Busy keeps tracking the lines while the interface is off.
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (~sda_s | ~scl_s) begin
      busy_q <= 1'b1; // R20
    end else if (stop_det) begin
      busy_q <= 1'b0; // R20
    end
  end
endmodule
`default_nettype wire

//--- i2c_status_flag_logic_props.sv
// Port-level checker of the status-flag block.
`timescale 1ns/1ps
`default_nettype none
module i2c_flag_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ev_arb_lost,
  input wire logic ev_tx_slot,
  input wire logic ev_byte_rx,
  input wire logic tx_go_q,
  input wire logic tx_resend_q,
  input wire logic rx_discard_q,
  input wire logic hold_clock_q,
  input wire logic release_bus_q
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_arb_release: assert property (ev_arb_lost |=> release_bus_q)
    else $error("bus not released after lost arbitration");
  a_release_cause: assert property (release_bus_q |-> $past(ev_arb_lost))
    else $error("bus released without lost arbitration");
  a_resend_cause: assert property (tx_resend_q |-> $past(ev_tx_slot) && !tx_go_q)
    else $error("resend outside a transmit slot");
  a_discard_cause: assert property (rx_discard_q |-> $past(ev_byte_rx))
    else $error("discard without a received byte");
  a_hold_cause: assert property ($rose(hold_clock_q) |-> $past(ev_tx_slot) || $past(ev_byte_rx))
    else $error("clock hold without a byte event");
endmodule
`default_nettype wire

//--- i2c_bus_peer.sv
// Model of the other bus parties making start and stop conditions.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_peer (
  input  wire logic aclk,
  output var  logic sda,
  output var  logic scl
);
  // Both lines have pull-ups, so a released bus reads high.
  initial begin
    sda = 1'b1;
    scl = 1'b1;
  end
  task automatic start_cond();
    @(posedge aclk);
    sda <= 1'b0;
    repeat (4) @(posedge aclk);
    scl <= 1'b0;
  endtask
  task automatic stop_cond();
    @(posedge aclk);
    sda <= 1'b0;
    repeat (4) @(posedge aclk);
    scl <= 1'b1;
    repeat (4) @(posedge aclk);
    sda <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb_i2c_status_flag_logic.sv
// Self-checking bench of the status-flag block over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_defs.vh"
module tb_i2c_status_flag_logic;
  localparam int SS = 0, SP = 1, AA = 2, AM = 3, NA = 4, AL = 5, RX = 6, TS = 7;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sda_in, scl_in;
  logic        ten_bit_mode, addr_second_byte, match_second, match_host;
  logic        match_default, match_gcall, addr_rw, byte_active;
  logic        tx_go_q, tx_resend_q, rx_discard_q, hold_clock_q, release_bus_q;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  evp, rx_byte, tx_byte_q;
  int          errors, checks;

  i2c_status_flag_logic i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sda_in, .scl_in, .ev_start_sent(evp[SS]),
    .ev_stop_sent(evp[SP]), .ev_addr_ack(evp[AA]), .ten_bit_mode, .addr_second_byte,
    .ev_addr_match(evp[AM]), .match_second, .match_host, .match_default, .match_gcall,
    .addr_rw, .ev_ack_missing(evp[NA]), .ev_arb_lost(evp[AL]), .byte_active,
    .ev_byte_rx(evp[RX]), .rx_byte, .ev_tx_slot(evp[TS]), .tx_byte_q, .tx_go_q,
    .tx_resend_q, .rx_discard_q, .hold_clock_q, .release_bus_q
  );
  i2c_bus_peer i_peer (.aclk(aclk), .sda(sda_in), .scl(scl_in));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_sim();
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // A handshake that never completes ends the run instead of hanging it.
  task automatic tmo(input int n);
    if (n >= 40) begin
      chk("handshake wait", n, 32'h0);
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40 && !(ad && wd && s_axi_bvalid); n++) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int   n;
    logic ad;
    ad = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40 && !(ad && s_axi_rvalid); n++) begin
      @(posedge aclk);
      ad = ad | s_axi_arready;
      s_axi_arvalid <= !ad;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic pulse(input int b);
    @(posedge aclk);
    evp[b] <= 1'b1;
    @(posedge aclk);
    evp[b] <= 1'b0;
  endtask
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ten_bit_mode, addr_second_byte, match_second, match_host, match_default} = '0;
    {match_gcall, addr_rw, byte_active, evp, rx_byte, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_EVENT, r);
    chk("event reset", r, 32'h0);
    rd(`OFS_BUS, r);
    chk("bus reset", r, 32'h0);
    rd(12'h010, r);
    chk("unmapped read", resp, `RESP_SLVERR);
    wr(12'h010, 32'h0);
    chk("unmapped write", resp, `RESP_SLVERR);
    wr(`OFS_CTRL, 32'h1);
    pulse(NA);
    pulse(AL);
    #1 chk("release", release_bus_q, 32'h1);
    rd(`OFS_EVENT, r);
    chk("ack fail", r[`EV_AF], 32'h1);
    chk("arb lost", r[`EV_ARB_LOST_FLAG], 32'h1);
    wr(`OFS_EVENT, 32'h200);
    rd(`OFS_EVENT, r);
    chk("ack fail clr", r[`EV_AF], 32'h0);
    chk("arb lost kept", r[`EV_ARB_LOST_FLAG], 32'h1);
    wr(`OFS_EVENT, 32'h0);
    byte_active <= 1'b1;
    i_peer.start_cond();
    settle();
    rd(`OFS_EVENT, r);
    chk("arb lost clr", r[`EV_ARB_LOST_FLAG], 32'h0);
    chk("bus error", r[`EV_BUS_ERROR_FLAG], 32'h1);
    rd(`OFS_BUS, r);
    chk("busy", r[`BS_BUSY], 32'h1);
    byte_active <= 1'b0;
    i_peer.stop_cond();
    settle();
    wr(`OFS_EVENT, 32'h0);
    rd(`OFS_BUS, r);
    chk("idle", r[`BS_BUSY], 32'h0);
    pulse(SS);
    rd(`OFS_EVENT, r);
    chk("bus error clr", r[`EV_BUS_ERROR_FLAG], 32'h0);
    chk("start sent", r[`EV_SB], 32'h1);
    {addr_rw, ten_bit_mode} <= 2'b01;
    pulse(AA);
    rd(`OFS_EVENT, r);
    chk("header", r[`EV_TEN_BIT_HEADER_SENT], 32'h1);
    chk("addr early", r[`EV_ADDR], 32'h0);
    wr(`OFS_CTRL, 32'h1);
    addr_second_byte <= 1'b1;
    pulse(AA);
    rd(`OFS_EVENT, r);
    chk("header clr", r[`EV_TEN_BIT_HEADER_SENT], 32'h0);
    chk("addr sent", r[`EV_ADDR], 32'h1);
    wr(`OFS_DATA, 32'h5a);
    rd(`OFS_EVENT, r);
    chk("start clr", r[`EV_SB], 32'h0);
    rd(`OFS_BUS, r);
    chk("master", r[`BS_MSL], 32'h1);
    chk("transmit", r[`BS_TRA], 32'h1);
    rd(`OFS_EVENT, r);
    chk("addr clr", r[`EV_ADDR], 32'h0);
    wr(`OFS_CTRL, 32'h3);
    pulse(TS);
    #1 chk("send", {tx_go_q, tx_byte_q}, 32'h15a);
    rd(`OFS_EVENT, r);
    chk("tx empty", r[`EV_TXE], 32'h1);
    pulse(TS);
    #1 chk("resend", tx_resend_q, 32'h1);
    rd(`OFS_EVENT, r);
    chk("underrun", r[`EV_OVR], 32'h1);
    pulse(SP);
    pulse(AL);
    rd(`OFS_EVENT, r);
    chk("tx empty clr", r[`EV_TXE], 32'h0);
    rd(`OFS_BUS, r);
    chk("role", {r[`BS_TRA], r[`BS_MSL]}, 32'h0);
    wr(`OFS_EVENT, 32'h0);
    wr(`OFS_CTRL, 32'h3d);
    {match_second, match_host, match_default, match_gcall} <= 4'hf;
    pulse(AM);
    rd(`OFS_BUS, r);
    chk("headers", r[7:4], 32'hf);
    i_peer.start_cond();
    settle();
    rd(`OFS_BUS, r);
    chk("headers clr", r[7:4], 32'h0);
    i_peer.stop_cond();
    settle();
    rd(`OFS_EVENT, r);
    chk("stop seen", r[`EV_STOP_SEEN_FLAG], 32'h1);
    wr(`OFS_CTRL, 32'h3d);
    rx_byte <= 8'h01;
    pulse(RX);
    rd(`OFS_EVENT, r);
    chk("stop clr", r[`EV_STOP_SEEN_FLAG], 32'h0);
    chk("rx full", r[`EV_RX_NOT_EMPTY_FLAG], 32'h1);
    rd(`OFS_BUS, r);
    chk("check value", r[15:8], 32'h07);
    rx_byte <= 8'h02;
    pulse(RX);
    #1 chk("hold", hold_clock_q, 32'h1);
    rd(`OFS_EVENT, r);
    chk("byte done", r[`EV_BTF], 32'h1);
    rd(`OFS_DATA, r);
    chk("rx first", r, 32'h01);
    rd(`OFS_EVENT, r);
    chk("byte done clr", {r[`EV_BTF], r[`EV_RX_NOT_EMPTY_FLAG]}, 32'h1);
    rd(`OFS_DATA, r);
    chk("rx second", r, 32'h02);
    rd(`OFS_EVENT, r);
    chk("rx empty", r[`EV_RX_NOT_EMPTY_FLAG], 32'h0);
    wr(`OFS_CTRL, 32'h3);
    rx_byte <= 8'h11;
    pulse(RX);
    rx_byte <= 8'h22;
    pulse(RX);
    #1 chk("discard", rx_discard_q, 32'h1);
    rd(`OFS_DATA, r);
    chk("rx kept", r, 32'h11);
    rd(`OFS_EVENT, r);
    chk("overrun", r[`EV_OVR], 32'h1);
    pulse(NA);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_EVENT, r);
    chk("off flags", r, 32'h0);
    i_peer.start_cond();
    settle();
    rd(`OFS_BUS, r);
    chk("off busy", r, 32'h2);
    end_sim();
  end
endmodule

bind i2c_status_flag_logic i2c_flag_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ev_arb_lost, .ev_tx_slot,
  .ev_byte_rx, .tx_go_q, .tx_resend_q, .rx_discard_q, .hold_clock_q, .release_bus_q
);
`default_nettype wire
